//--- logic/mceb_machine_check_bank.sv
// Machine-check error banks, exception ordering, stop-grant and debug matches
`timescale 1ns/1ps
`default_nettype none
`include "mceb_params.svh"

module mceb_machine_check_bank
  import mceb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire mceb_reg_t regReq,
  output logic [31:0] regRdata,
  input wire mceb_err_t errIn,
  input wire logic sectorHalfB,
  input wire logic fetchHalfCorr,
  input wire logic [63:0] pendingAddr,
  input wire logic prefetchHit,
  input wire logic stop_clock_request_n,
  input wire logic system_management_interrupt_n,
  input wire logic smiDone,
  input wire logic [`MCEB_DBG_W-1:0] dbgMatch,
  input wire logic dbgEntry,
  output logic machineCheckException,
  output logic smiTaken,
  output logic stopGrantCycle,
  output logic stopGranted,
  output logic halfCorrected,
  output logic irq
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] stopSync_q;
  logic [2:0] smiSync_q;
  logic stopReq_q;
  logic smiReq_q;

  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stopSync_q <= 3'h7;
      smiSync_q <= 3'h7;
      stopReq_q <= 1'b0;
      smiReq_q <= 1'b0;
    end else if (clkEn) begin
      stopSync_q <= {stopSync_q[1:0], stop_clock_request_n};
      smiSync_q <= {smiSync_q[1:0], system_management_interrupt_n};
      if (stopSync_q[1] == stopSync_q[2]) begin
        stopReq_q <= ~stopSync_q[2];
      end
      if (smiSync_q[1] == smiSync_q[2]) begin
        smiReq_q <= ~smiSync_q[2];
      end
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [63:0] b0Status_q;
  logic [63:0] b1Status_q;
  logic [63:0] b1Addr_q;
  logic [63:0] b2Status_q;
  logic [31:0] b2Ctl_q;
  logic [31:0] control_q;
  logic [`MCEB_IRQ_W-1:0] irqStatus_q;
  logic [`MCEB_IRQ_W-1:0] irqMask_q;
  logic [`MCEB_DBG_W-1:0] dbgStatus_q;
  logic [`MCEB_DBG_W-1:0] dbgControl_q;
  logic cleared_q;
  logic wrHit;

  function automatic logic isWr(input mceb_reg_t r, input logic [7:0] off);
    isWr = r.wr && (r.addr == off);
  endfunction

  // Merge an error into one bank's status word
  function automatic logic [63:0] logErr(input logic [63:0] st,
                                         input mceb_err_t e,
                                         input logic keepFirst);
    logic [63:0] n;
    n = st;
    if (keepFirst && st[`MCEB_ST_VALID] && st[`MCEB_ST_UNCORRECTABLE_FLAG]) begin
      n[`MCEB_ST_CODE_W-1:0] = e.code;
    end else begin
      n[`MCEB_ST_CODE_W-1:0] = e.code;
      n[`MCEB_ST_UNCORRECTABLE_FLAG] = st[`MCEB_ST_UNCORRECTABLE_FLAG] | e.uncorrectable_flag;
      n[`MCEB_ST_PCC] = st[`MCEB_ST_PCC] | e.context_corrupt_flag;
      n[`MCEB_ST_HARDFAIL] = st[`MCEB_ST_HARDFAIL] | e.hardFail;
      n[`MCEB_ST_EN] = 1'b1;
    end
    if (st[`MCEB_ST_VALID]) begin
      n[`MCEB_ST_OVER] = 1'b1;
    end
    n[`MCEB_ST_VALID] = 1'b1;
    logErr = n;
  endfunction

  logic logOk;
  logic specDrop;
  assign logOk = cleared_q && errIn.valid;
  assign specDrop = errIn.speculative && errIn.l2Hit && !errIn.uncorrectable_flag;

  // Post-reset clearing pass; software may also request one
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cleared_q <= 1'b0;
    end else if (clkEn) begin
      cleared_q <= 1'b1;
    end
  end

  // Bank 0: bus and sector errors
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      b0Status_q <= 64'h0;
    end else if (clkEn) begin
      if (!cleared_q || (isWr(regReq, `MCEB_OFF_CONTROL)
          && regReq.wdata[`MCEB_CTL_CLEAR])) begin
        b0Status_q <= 64'h0;
      end else if (logOk && errIn.bank == 2'h0) begin
        b0Status_q <= logErr(b0Status_q, errIn, 1'b1);
        if (sectorHalfB) begin
          b0Status_q[`MCEB_ST_OVER] <= 1'b1;
        end
      end else if (isWr(regReq, `MCEB_OFF_B0_STATUS_LO)) begin
        b0Status_q[31:0] <= regReq.wdata;
      end else if (isWr(regReq, `MCEB_OFF_B0_STATUS_HI)) begin
        b0Status_q[63:32] <= regReq.wdata;
      end
    end
  end

  // Bank 1: first-level cache errors and their address
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      b1Status_q <= 64'h0;
      b1Addr_q <= 64'h0;
    end else if (clkEn) begin
      if (!cleared_q || (isWr(regReq, `MCEB_OFF_CONTROL)
          && regReq.wdata[`MCEB_CTL_CLEAR])) begin
        b1Status_q <= 64'h0;
        b1Addr_q <= 64'h0;
      end else if (logOk && errIn.bank == 2'h1 && !specDrop) begin
        b1Status_q <= logErr(b1Status_q, errIn, 1'b0);
        if (sectorHalfB) begin
          b1Status_q[`MCEB_ST_OVER] <= 1'b1;
        end
        b1Status_q[`MCEB_ST_ADDRV] <= errIn.l1Parity && errIn.addrOk;
        if (errIn.l1Parity && errIn.addrOk) begin
          b1Addr_q <= errIn.addr;
        end
      end else if (isWr(regReq, `MCEB_OFF_B1_STATUS_LO)) begin
        b1Status_q[31:0] <= regReq.wdata;
      end else if (isWr(regReq, `MCEB_OFF_B1_STATUS_HI)) begin
        b1Status_q[63:32] <= regReq.wdata;
      end
    end
  end

  // Bank 2 and its reporting control
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      b2Status_q <= 64'h0;
      b2Ctl_q <= `MCEB_RST_B2CTL;
    end else if (clkEn) begin
      if (isWr(regReq, `MCEB_OFF_B2_CTL)) begin
        b2Ctl_q <= regReq.wdata;
      end
      if (!cleared_q || (isWr(regReq, `MCEB_OFF_CONTROL)
          && regReq.wdata[`MCEB_CTL_CLEAR])) begin
        b2Status_q <= 64'h0;
      end else if (logOk && errIn.bank == 2'h2) begin
        b2Status_q <= logErr(b2Status_q, errIn, 1'b0);
      end else if (isWr(regReq, `MCEB_OFF_B2_STATUS_LO)) begin
        b2Status_q[31:0] <= regReq.wdata;
      end else if (isWr(regReq, `MCEB_OFF_B2_STATUS_HI)) begin
        b2Status_q[63:32] <= regReq.wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // Exception raising and ordering
  // ------------------------------------------------------------
  logic raise;
  logic deferred_q;
  logic [63:0] deferAddr_q;
  logic smiPend_q;

  // Prefetch tag errors raise at once only when also flagged ioData; otherwise a later hit does
  always_comb begin
    raise = 1'b0;
    if (logOk && errIn.uncorrectable_flag && !errIn.prefetchTag) begin
      raise = !(errIn.bank == 2'h2 && b2Ctl_q == 32'h0);
    end
    if (logOk && errIn.ioData) begin
      raise = 1'b1;
    end
    if (deferred_q && prefetchHit && pendingAddr == deferAddr_q) begin
      raise = 1'b1;
    end
    raise = raise && control_q[`MCEB_CTL_MCEN];
  end

  // Remember the prefetched line with a bad tag
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      deferred_q <= 1'b0;
      deferAddr_q <= 64'h0;
    end else if (clkEn) begin
      if (logOk && errIn.uncorrectable_flag && errIn.prefetchTag) begin
        deferred_q <= 1'b1;
        deferAddr_q <= errIn.addr;
      end else if (deferred_q && prefetchHit
                   && pendingAddr == deferAddr_q) begin
        deferred_q <= 1'b0;
      end
    end
  end

  // Exception pulse and interrupt hold-off
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      machineCheckException <= 1'b0;
      smiPend_q <= 1'b0;
      smiTaken <= 1'b0;
    end else if (clkEn) begin
      machineCheckException <= raise;
      smiTaken <= 1'b0;
      if (smiReq_q && !smiPend_q) begin
        smiPend_q <= 1'b1;
      end else if (smiPend_q && !raise && !machineCheckException) begin
        smiTaken <= 1'b1;
        smiPend_q <= smiDone ? 1'b0 : smiPend_q;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      halfCorrected <= 1'b0;
    end else if (clkEn) begin
      halfCorrected <= errIn.valid && fetchHalfCorr;
    end
  end

  // ------------------------------------------------------------
  // Stop-grant sequence
  // ------------------------------------------------------------
  mceb_stop_t stop_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_q <= MCEB_RUN;
      stopGrantCycle <= 1'b0;
      stopGranted <= 1'b0;
    end else if (clkEn) begin
      stopGrantCycle <= 1'b0;
      case (stop_q)
        MCEB_RUN: begin
          if (stopReq_q) begin
            stop_q <= MCEB_STOPPING;
            stopGranted <= 1'b1;
          end
        end
        MCEB_STOPPING: begin
          // Hold the ack while an exception is leaving, so the handler
          // fetch is not lost after the chipset stops listening
          if (!raise && !machineCheckException) begin
            stop_q <= MCEB_GRANTED;
            stopGrantCycle <= 1'b1;
          end
        end
        MCEB_GRANTED: begin
          if (!stopReq_q) begin
            stop_q <= MCEB_RUN;
            stopGranted <= 1'b0;
          end
        end
        default: stop_q <= MCEB_RUN;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Debug matches, control, interrupts
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dbgStatus_q <= '0;
      dbgControl_q <= '0;
    end else if (clkEn) begin
      if (isWr(regReq, `MCEB_OFF_DBG_CONTROL)) begin
        dbgControl_q <= regReq.wdata[`MCEB_DBG_W-1:0];
      end
      if (dbgEntry && |(dbgMatch & dbgControl_q)) begin
        dbgStatus_q <= dbgMatch;
      end else if (isWr(regReq, `MCEB_OFF_DBG_STATUS)) begin
        dbgStatus_q <= regReq.wdata[`MCEB_DBG_W-1:0];
      end
    end
  end

  logic [`MCEB_IRQ_W-1:0] irqSet;
  assign irqSet = {dbgEntry && |(dbgMatch & dbgControl_q),
                   stopGrantCycle,
                   logOk && sectorHalfB,
                   raise};
  assign wrHit = isWr(regReq, `MCEB_OFF_IRQ_STATUS);

  // Sticky events; a set in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStatus_q <= '0;
      irqMask_q <= '0;
      control_q <= `MCEB_RST_CONTROL;
      irq <= 1'b0;
    end else if (clkEn) begin
      irqStatus_q <= (irqStatus_q
          & ~(wrHit ? regReq.wdata[`MCEB_IRQ_W-1:0] : '0)) | irqSet;
      if (isWr(regReq, `MCEB_OFF_IRQ_MASK)) begin
        irqMask_q <= regReq.wdata[`MCEB_IRQ_W-1:0];
      end
      if (isWr(regReq, `MCEB_OFF_CONTROL)) begin
        control_q <= {31'h0, regReq.wdata[`MCEB_CTL_MCEN]};
      end
      irq <= |(irqStatus_q & irqMask_q);
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 32'h0;
    end else if (clkEn) begin
      regRdata <= 32'h0;
      if (regReq.rd) begin
        case (regReq.addr)
          `MCEB_OFF_B0_STATUS_LO: regRdata <= b0Status_q[31:0];
          `MCEB_OFF_B0_STATUS_HI: regRdata <= b0Status_q[63:32];
          `MCEB_OFF_B1_STATUS_LO: regRdata <= b1Status_q[31:0];
          `MCEB_OFF_B1_STATUS_HI: regRdata <= b1Status_q[63:32];
          `MCEB_OFF_B1_ADDR_LO: regRdata <= b1Addr_q[31:0];
          `MCEB_OFF_B1_ADDR_HI: regRdata <= b1Addr_q[63:32];
          `MCEB_OFF_B2_STATUS_LO: regRdata <= b2Status_q[31:0];
          `MCEB_OFF_B2_STATUS_HI: regRdata <= b2Status_q[63:32];
          `MCEB_OFF_B2_CTL: regRdata <= b2Ctl_q;
          `MCEB_OFF_CONTROL: regRdata <= control_q;
          `MCEB_OFF_IRQ_STATUS: regRdata <= {28'h0, irqStatus_q};
          `MCEB_OFF_IRQ_MASK: regRdata <= {28'h0, irqMask_q};
          `MCEB_OFF_DBG_STATUS: regRdata <= {28'h0, dbgStatus_q};
          `MCEB_OFF_DBG_CONTROL: regRdata <= {28'h0, dbgControl_q};
          `MCEB_OFF_STATE: regRdata <= {28'h0, smiPend_q, deferred_q, stop_q};
          default: regRdata <= 32'h0;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

//--- logic/mceb_params.svh
// Constants for the machine-check error bank block
`ifndef MCEB_PARAMS_SVH
`define MCEB_PARAMS_SVH
// Register offsets on the plain register port
`define MCEB_OFF_B0_STATUS_LO 8'h00
`define MCEB_OFF_B0_STATUS_HI 8'h04
`define MCEB_OFF_B1_STATUS_LO 8'h08
`define MCEB_OFF_B1_STATUS_HI 8'h0c
`define MCEB_OFF_B1_ADDR_LO 8'h10
`define MCEB_OFF_B1_ADDR_HI 8'h14
`define MCEB_OFF_B2_STATUS_LO 8'h18
`define MCEB_OFF_B2_STATUS_HI 8'h1c
`define MCEB_OFF_B2_CTL 8'h20
`define MCEB_OFF_CONTROL 8'h24
`define MCEB_OFF_IRQ_STATUS 8'h28
`define MCEB_OFF_IRQ_MASK 8'h2c
`define MCEB_OFF_DBG_STATUS 8'h30
`define MCEB_OFF_DBG_CONTROL 8'h34
`define MCEB_OFF_STATE 8'h38
// Status field positions (64-bit bank status)
`define MCEB_ST_VALID 63
`define MCEB_ST_OVER 62
`define MCEB_ST_UNCORRECTABLE_FLAG 61
`define MCEB_ST_EN 60
`define MCEB_ST_MISCV 59
`define MCEB_ST_ADDRV 58
`define MCEB_ST_PCC 57
`define MCEB_ST_HARDFAIL 16
`define MCEB_ST_CODE_W 16
// Control register fields
`define MCEB_CTL_MCEN 0
`define MCEB_CTL_CLEAR 1
// Interrupt event bits
`define MCEB_IRQ_W 4
`define MCEB_IRQ_MCE 0
`define MCEB_IRQ_OVER 1
`define MCEB_IRQ_STOPGNT 2
`define MCEB_IRQ_DBG 3
// Reset values
`define MCEB_RST_B2CTL 32'hffffffff
`define MCEB_RST_CONTROL 32'h00000000
`define MCEB_DBG_W 4
`endif

//--- logic/mceb_pkg.sv
// Types for the machine-check error bank block
package mceb_pkg;
  // One error report from the cache/bus pipelines
  typedef struct packed {
    logic valid;
    logic [1:0] bank;
    logic uncorrectable_flag;
    logic context_corrupt_flag;
    logic speculative;
    logic l2Hit;
    logic l1Parity;
    logic addrOk;
    logic prefetchTag;
    logic hardFail;
    logic ioData;
    logic [15:0] code;
    logic [63:0] addr;
  } mceb_err_t;
  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } mceb_reg_t;
  typedef enum logic [1:0] {
    MCEB_RUN = 2'b00,
    MCEB_STOPPING = 2'b01,
    MCEB_GRANTED = 2'b10
  } mceb_stop_t;
endpackage

//--- sim/mceb_chipset_model.sv
// Behavioural chipset model driving stop and system interrupt pins
`timescale 1ns/1ps
`default_nettype none
module mceb_chipset_model #(
  parameter int SMI_DELAY = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic stopCmd,
  input wire logic smiCmd,
  input wire logic stopGrantCycle,
  input wire logic smiTaken,
  output logic stop_clock_request_n,
  output logic system_management_interrupt_n,
  output logic smiDone,
  output logic busIgnored
);
  // ----------------
  // Pins
  // ----------------
  logic smiBusy_q;
  int smiCnt_q;
  // Stop pin follows the command from the bench
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_clock_request_n <= 1'b1;
      busIgnored <= 1'b0;
    end else begin
      stop_clock_request_n <= !stopCmd;
      if (stopGrantCycle) begin
        busIgnored <= 1'b1;
      end
    end
  end
  // Interrupt held until taken; a slow handler then reports completion
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      system_management_interrupt_n <= 1'b1;
      smiDone <= 1'b0;
      smiBusy_q <= 1'b0;
      smiCnt_q <= 0;
    end else begin
      smiDone <= 1'b0;
      if (smiCmd && !smiBusy_q) begin
        system_management_interrupt_n <= 1'b0;
        smiBusy_q <= 1'b1;
      end else if (smiBusy_q && (smiTaken || smiCnt_q != 0)) begin
        system_management_interrupt_n <= 1'b1;
        smiCnt_q <= smiCnt_q + 1;
        if (smiCnt_q == SMI_DELAY) begin
          smiDone <= 1'b1;
          smiBusy_q <= 1'b0;
          smiCnt_q <= 0;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/mceb_machine_check_bank_chk.sv
// Port-level assertions for the machine-check error bank
`timescale 1ns/1ps
`default_nettype none
module mceb_machine_check_bank_chk
  import mceb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire mceb_reg_t regReq,
  input wire logic [31:0] regRdata,
  input wire mceb_err_t errIn,
  input wire logic fetchHalfCorr,
  input wire logic prefetchHit,
  input wire logic stop_clock_request_n,
  input wire logic machineCheckException,
  input wire logic smiTaken,
  input wire logic stopGrantCycle,
  input wire logic stopGranted,
  input wire logic halfCorrected
);
  // ----------------
  // Checks
  // ----------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // Stop request asserted and held long enough to pass the synchroniser
  sequence s_stop_req;
    $fell(stop_clock_request_n) ##1 !stop_clock_request_n [*3];
  endsequence
  // Acknowledge cycle follows within a bounded time
  sequence s_stop_ack;
    ##[1:20] stopGrantCycle;
  endsequence
  a_rdata_idle: assert property ((clkEn && !regReq.rd) |=> regRdata == 32'h0)
    else $error("read data not zero outside a read answer");
  a_mce_cause: assert property (
    machineCheckException |-> ($past(errIn.valid) || $past(prefetchHit)))
    else $error("exception without an error or deferred access");
  a_smi_yields: assert property (machineCheckException |-> !smiTaken)
    else $error("interrupt taken beside an exception");
  a_stop_order: assert property (stopGrantCycle |-> stopGranted)
    else $error("acknowledge cycle before grant state");
  a_ack_no_mce: assert property (stopGrantCycle |-> !machineCheckException)
    else $error("acknowledge cycle beside an exception");
  a_grant_cause: assert property (
    $rose(stopGranted) |-> $past(!stop_clock_request_n, 2))
    else $error("grant state without a stop request");
  a_stop_acked: assert property (s_stop_req |-> s_stop_ack)
    else $error("stop request never acknowledged");
  a_ack_pulse: assert property (stopGrantCycle |=> !stopGrantCycle)
    else $error("acknowledge cycle longer than one clock");
  // A reported fetch error with a correctable half gives the corrected half next cycle
  a_half_corr: assert property (
    (clkEn && errIn.valid && fetchHalfCorr) |=> halfCorrected)
    else $error("correctable fetch half not corrected");
endmodule
`default_nettype wire

//--- sim/mceb_machine_check_bank_tb_top.sv
// Self-checking bench for the machine-check error bank
`timescale 1ns/1ps
`default_nettype none
module mceb_machine_check_bank_tb_top
  import mceb_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  mceb_reg_t regReq = '0;
  mceb_err_t errIn = '0;
  logic sectorHalfB = 1'b0;
  logic fetchHalfCorr = 1'b0;
  logic [63:0] pendingAddr = 64'h0;
  logic prefetchHit = 1'b0;
  logic [3:0] dbgMatch = 4'h0;
  logic dbgEntry = 1'b0;
  logic stopCmd = 1'b0;
  logic smiCmd = 1'b0;
  logic [31:0] regRdata;
  logic stopN, smiN, smiDone, busIgnored, got;
  logic machineCheckException, smiTaken, stopGrantCycle, stopGranted;
  logic halfCorrected, irq;
  int miscompares = 0;
  int checksDone = 0;
  int cycles = 0;
  // ----------------
  // Harness
  // ----------------
  always #5 ref_clk = ~ref_clk;
  mceb_machine_check_bank i_mceb_machine_check_bank (.ref_clk(ref_clk),
    .rst_n(rst_n), .clkEn(1'b1), .regReq(regReq), .regRdata(regRdata),
    .errIn(errIn), .sectorHalfB(sectorHalfB), .fetchHalfCorr(fetchHalfCorr),
    .pendingAddr(pendingAddr), .prefetchHit(prefetchHit),
    .stop_clock_request_n(stopN), .system_management_interrupt_n(smiN),
    .smiDone(smiDone), .dbgMatch(dbgMatch), .dbgEntry(dbgEntry),
    .machineCheckException(machineCheckException), .smiTaken(smiTaken),
    .stopGrantCycle(stopGrantCycle), .stopGranted(stopGranted),
    .halfCorrected(halfCorrected), .irq(irq));
  mceb_chipset_model i_mceb_chipset_model (.ref_clk(ref_clk), .rst_n(rst_n),
    .stopCmd(stopCmd), .smiCmd(smiCmd), .stopGrantCycle(stopGrantCycle),
    .smiTaken(smiTaken), .stop_clock_request_n(stopN),
    .system_management_interrupt_n(smiN), .smiDone(smiDone),
    .busIgnored(busIgnored));
  // Hang guard: the whole sequence needs well under this many cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checksDone++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regReq <= mceb_reg_t'({1'b1, 1'b0, a, d});
    @(posedge ref_clk);
    regReq <= '0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    @(posedge ref_clk);
    regReq <= mceb_reg_t'({1'b0, 1'b1, a, 32'h0});
    @(posedge ref_clk);
    regReq <= '0;
    #1 chk(regRdata & m, e);
  endtask
  // One error report; got holds the exception output a cycle later
  task automatic err(input logic [1:0] b, input logic [8:0] f,
                     input logic [15:0] c, input logic [63:0] a,
                     input logic s);
    @(posedge ref_clk);
    errIn <= mceb_err_t'({1'b1, b, f, c, a});
    sectorHalfB <= s;
    @(posedge ref_clk);
    errIn <= '0;
    sectorHalfB <= 1'b0;
    #1 got = machineCheckException;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----------------
  // Tests
  // ----------------
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    // An error in the clearing cycle must not survive it
    errIn <= mceb_err_t'({1'b1, 2'd0, 9'h100, 16'h0, 64'h0});
    @(posedge ref_clk);
    errIn <= '0;
    repeat (2) @(posedge ref_clk);
    rd(8'h24, 32'hffffffff, 32'h0);
    rd(8'h20, 32'hffffffff, 32'hffffffff);
    rd(8'h04, 32'hffffffff, 32'h0);
    rd(8'h3c, 32'hffffffff, 32'h0);
    err(2'd0, 9'h180, 16'h0011, 64'h0, 1'b0);
    chk(got, 1'b0);
    rd(8'h04, 32'h80000000, 32'h80000000);
    wr(8'h24, 32'h3);
    err(2'd0, 9'h180, 16'h0011, 64'h0, 1'b0);
    chk(got, 1'b1);
    #1 chk(irq, 1'b0);
    rd(8'h28, 32'h1, 32'h1);
    wr(8'h2c, 32'hf);
    repeat (2) @(posedge ref_clk);
    #1 chk(irq, 1'b1);
    wr(8'h28, 32'hf);
    repeat (2) @(posedge ref_clk);
    #1 chk(irq, 1'b0);
    err(2'd0, 9'h100, 16'h0022, 64'h0, 1'b0);
    rd(8'h04, 32'he2000000, 32'he2000000);
    rd(8'h00, 32'h0000ffff, 32'h00000022);
    $display("test logging done");
    wr(8'h24, 32'h3);
    err(2'd0, 9'h002, 16'h0005, 64'h0, 1'b0);
    rd(8'h00, 32'h00010000, 32'h00010000);
    wr(8'h20, 32'h0);
    err(2'd2, 9'h180, 16'h0, 64'h0, 1'b0);
    chk(got, 1'b0);
    rd(8'h1c, 32'ha0000000, 32'ha0000000);
    err(2'd1, 9'h018, 16'h0, 64'h0000001234567890, 1'b0);
    rd(8'h10, 32'hffffffff, 32'h34567890);
    rd(8'h14, 32'hffffffff, 32'h00000012);
    rd(8'h0c, 32'h04000000, 32'h04000000);
    wr(8'h24, 32'h3);
    err(2'd1, 9'h010, 16'h0, 64'h0, 1'b0);
    rd(8'h0c, 32'h04000000, 32'h0);
    wr(8'h24, 32'h3);
    err(2'd1, 9'h060, 16'h0, 64'h0, 1'b0);
    rd(8'h0c, 32'hffffffff, 32'h0);
    err(2'd1, 9'h000, 16'h0, 64'h0, 1'b1);
    rd(8'h0c, 32'hc0000000, 32'hc0000000);
    $display("test banks done");
    wr(8'h24, 32'h3);
    err(2'd0, 9'h184, 16'h0, 64'h40, 1'b0);
    chk(got, 1'b0);
    rd(8'h04, 32'h22000000, 32'h22000000);
    @(posedge ref_clk);
    pendingAddr <= 64'h40;
    prefetchHit <= 1'b1;
    @(posedge ref_clk);
    prefetchHit <= 1'b0;
    #1 chk(machineCheckException, 1'b1);
    // Interrupt becomes pending just as the exception fires
    @(posedge ref_clk);
    smiCmd <= 1'b1;
    @(posedge ref_clk);
    smiCmd <= 1'b0;
    repeat (4) @(posedge ref_clk);
    err(2'd0, 9'h181, 16'h0, 64'h0, 1'b0);
    chk(got, 1'b1);
    chk(smiTaken, 1'b0);
    got = 1'b0;
    repeat (30) begin
      @(posedge ref_clk);
      #1 if (smiTaken === 1'b1) got = 1'b1;
    end
    chk(got, 1'b1);
    wr(8'h34, 32'h1);
    @(posedge ref_clk);
    dbgMatch <= 4'h5;
    dbgEntry <= 1'b1;
    @(posedge ref_clk);
    dbgEntry <= 1'b0;
    rd(8'h30, 32'hf, 32'h5);
    @(posedge ref_clk);
    fetchHalfCorr <= 1'b1;
    errIn <= mceb_err_t'({1'b1, 2'd0, 9'h100, 16'h0, 64'h0});
    @(posedge ref_clk);
    fetchHalfCorr <= 1'b0;
    errIn <= '0;
    #1 chk(halfCorrected, 1'b1);
    @(posedge ref_clk);
    stopCmd <= 1'b1;
    got = 1'b0;
    repeat (30) begin
      @(posedge ref_clk);
      #1 if (stopGrantCycle === 1'b1) got = 1'b1;
    end
    chk(got, 1'b1);
    chk(stopGranted, 1'b1);
    chk(busIgnored, 1'b1);
    rd(8'h28, 32'h4, 32'h4);
    $display("test ordering done");
    finish_test();
  end
endmodule
bind mceb_machine_check_bank mceb_machine_check_bank_chk
  i_mceb_machine_check_bank_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .clkEn(clkEn), .regReq(regReq), .regRdata(regRdata), .errIn(errIn),
  .fetchHalfCorr(fetchHalfCorr), .prefetchHit(prefetchHit),
  .stop_clock_request_n(stop_clock_request_n),
  .machineCheckException(machineCheckException), .smiTaken(smiTaken),
  .stopGrantCycle(stopGrantCycle), .stopGranted(stopGranted),
  .halfCorrected(halfCorrected));
`default_nettype wire
